// *** cncd_pkg.sv ***
// Purpose: Shared constants and types of the chain node command decoder.
// Assumes: One 10 MHz system clock; frames arrive as whole 48-bit words.
// Notes: Timeout length is a plain default; the top module may override it.
`default_nettype none

package cncd_pkg;

  // Frame geometry
  localparam int unsigned FRAME_W = 48;
  localparam int unsigned CHECK_LSB = 0; // Check byte 7:0
  localparam int unsigned CMD_LSB = 8; // Command 9:8
  localparam int unsigned RSVA_LSB = 10; // Reserved 11:10
  localparam int unsigned SEQ_LSB = 12; // Sequence count 15:12
  localparam int unsigned NODE_LSB = 16; // Node address 21:16
  localparam int unsigned RSVB_LSB = 22; // Reserved 23:22
  localparam int unsigned REGA_LSB = 24; // Register address 30:24
  localparam int unsigned DIR_BIT = 31; // Direction flag
  localparam int unsigned DATA_LSB = 32; // Payload 47:32

  // Command codes
  localparam logic [1:0] CMD_KEEPALIVE = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_GLOBAL = 2'h3;

  // Fixed field values
  localparam logic DIR_COMMAND = 1'h0; // Sent by the pack controller
  localparam logic DIR_RESPONSE = 1'h1; // Sent by a node
  localparam logic [1:0] RSV_ZERO = 2'h0;
  localparam logic [7:0] CHECK_PLACEHOLDER = 8'h00; // Filled in by the framer

  // Addresses and reset values
  localparam logic [6:0] RESERVED_REG_ADDR = 7'h00;
  localparam logic [6:0] INIT_REG_ADDR = 7'h01; // Address-assign register
  localparam int unsigned INIT_NODE_LSB = 0; // Node address field inside it
  localparam logic [5:0] DEFAULT_NODE_ADDR = 6'h00;
  localparam logic [3:0] SEQ_RESET = 4'h0;
  localparam logic [6:0] XFER_MAX = 7'h7F;

  // Timing
  localparam int unsigned CLK_FREQ_HZ = 10_000_000;
  localparam int unsigned COMM_TIMEOUT_MS = 1000;
  localparam int unsigned COMM_TIMEOUT_CYCLES = COMM_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);

  // Read sequencer states
  typedef enum logic [1:0] {
    CNCD_IDLE,
    CNCD_FETCH,
    CNCD_SEND
  } cncd_state_t;

endpackage : cncd_pkg

`default_nettype wire

// *** cncd_decoder.sv ***
// Purpose: Decode controller frames for one daisy-chained cell controller node.
// Assumes: Framing and check-byte checking are done upstream on the same clock.
// Notes: Register storage lives outside; this block drives its write and read ports.
// Function
// RULE1 - Keepalive frame restarts the communication timeout
// RULE2 - Keepalive changes nothing and sends no response
// RULE3 - Timeout expiry resets node, clears node address
// RULE4 - Controller sends keepalives before timeout elapses
// RULE5 - Fixed 48-bit field layout of every frame
// RULE6 - Codes: keepalive, read, addressed write, global write
// RULE7 - Controller sends commands with direction flag clear
// RULE8 - Unassigned node accepts only address-assign writes; code also accepts reads addressed to node 0
// RULE9 - Nodes start at node address zero
// RULE10 - Controller assigns unique addresses before other access
// RULE11 - Frames with direction flag set are ignored
// RULE12 - Read response layout: flag, zeros, command, data
// RULE13 - Response sequence count starts zero, wraps, increments
// RULE14 - Writes update register silently; read-only stays unchanged
// RULE15 - Bad check byte frames are fully discarded
// RULE16 - Addressed commands need matching node address
`default_nettype none

module cncd_decoder #(
  parameter int unsigned TIMEOUT_CYCLES = cncd_pkg::COMM_TIMEOUT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic frame_valid_i, // Received frame strobe
  input wire logic [47:0] frame_i, // Received frame word
  input wire logic check_ok_i, // Check byte matched, qualifies frame_valid_i
  output logic frame_ready_o, // Decoder can take a frame
  output logic wr_en_o, // Register write strobe
  output logic wr_global_o, // Write came from a global frame
  output logic [6:0] wr_addr_o,
  output logic [15:0] wr_data_o,
  output logic rd_req_o, // Register read strobe
  output logic [6:0] rd_addr_o,
  input wire logic [15:0] rd_data_i, // Read data, valid while rd_req_o is high
  output logic resp_valid_o, // Response frame offered
  output logic [47:0] resp_frame_o,
  input wire logic resp_ready_i, // Transmitter takes the response
  output logic [5:0] node_address_o,
  output logic initialized_o, // Node address is not the default
  output logic soft_reset_o // One-cycle node reset on timeout
);

  // Frame fields, named from their job
  wire logic [1:0] cmd_w = frame_i[cncd_pkg::CMD_LSB +: 2]; // see RULE5
  wire logic [5:0] node_w = frame_i[cncd_pkg::NODE_LSB +: 6];
  wire logic [6:0] rega_w = frame_i[cncd_pkg::REGA_LSB +: 7];
  wire logic dir_w = frame_i[cncd_pkg::DIR_BIT];
  wire logic [15:0] data_w = frame_i[cncd_pkg::DATA_LSB +: 16];

  // Registered state
  cncd_pkg::cncd_state_t state_q;
  logic [5:0] node_address_q; // Programmed node address
  logic [3:0] response_sequence_count_q; // Tags each transmitted response
  logic [6:0] register_transfer_count_q; // Registers still to send
  logic [6:0] rd_addr_q;
  logic rd_req_q;
  logic [47:0] resp_frame_q;
  logic resp_valid_q;
  logic wr_en_q;
  logic wr_global_q;
  logic [6:0] wr_addr_q;
  logic [15:0] wr_data_q;
  logic soft_reset_q;
  logic [31:0] timeout_cnt_q;

  // Acceptance decode
  wire logic idle_w = (state_q == cncd_pkg::CNCD_IDLE);
  wire logic taken_w = frame_valid_i & idle_w;
  // Frames from other nodes carry the response flag; drop them whole
  wire logic good_w = taken_w & check_ok_i & (dir_w == cncd_pkg::DIR_COMMAND); // see RULE15, see RULE11
  wire logic unassigned_w = (node_address_q == cncd_pkg::DEFAULT_NODE_ADDR);
  wire logic mine_w = (node_w == node_address_q); // see RULE16
  wire logic is_init_w = (rega_w == cncd_pkg::INIT_REG_ADDR);
  wire logic is_rsvd_w = (rega_w == cncd_pkg::RESERVED_REG_ADDR);
  // Before assignment only the address-assign register takes writes
  wire logic wr_allowed_w = ~unassigned_w | is_init_w; // see RULE8
  wire logic do_write_w = good_w & mine_w & (cmd_w == cncd_pkg::CMD_WRITE)
                          & wr_allowed_w & ~is_rsvd_w; // see RULE14
  // Global writes skip the address compare; node address cannot be set this way
  wire logic do_global_w = good_w & (cmd_w == cncd_pkg::CMD_GLOBAL)
                           & wr_allowed_w & ~is_rsvd_w & ~is_init_w; // see RULE6, see RULE16
  wire logic do_read_w = good_w & mine_w & (cmd_w == cncd_pkg::CMD_READ); // see RULE6
  // Keepalive falls through every action term; only the timer sees it
  wire logic restart_w = good_w; // see RULE1, see RULE2
  wire logic set_addr_w = do_write_w & is_init_w; // see RULE9, see RULE10
  wire logic [5:0] new_addr_w = data_w[cncd_pkg::INIT_NODE_LSB +: 6];

  // Timeout compare
  wire logic expire_w = (timeout_cnt_q >= (TIMEOUT_CYCLES - 32'd1)); // see RULE3

  // Read sequencing
  wire logic [6:0] xfer_w = (data_w[6:0] == 7'h00) ? 7'h01 : data_w[6:0]; // Zero means one
  wire logic resp_done_w = resp_valid_q & resp_ready_i;
  wire logic last_w = (register_transfer_count_q == 7'h01);

  // Response frame assembly
  function automatic logic [47:0] cncd_build_resp(input logic [15:0] data,
                                                  input logic [6:0] rega,
                                                  input logic [5:0] node,
                                                  input logic [3:0] seq);
    cncd_build_resp = {data, cncd_pkg::DIR_RESPONSE, rega, cncd_pkg::RSV_ZERO, node,
                       seq, cncd_pkg::RSV_ZERO, cncd_pkg::CMD_READ,
                       cncd_pkg::CHECK_PLACEHOLDER}; // see RULE12
  endfunction : cncd_build_resp

  // Communication timeout counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timeout_cnt_q <= 32'h00000000;
    end else if (restart_w || expire_w) begin
      timeout_cnt_q <= 32'h00000000; // see RULE1
    end else begin
      timeout_cnt_q <= timeout_cnt_q + 32'h00000001;
    end
  end

  // Soft reset pulse, one cycle per expiry
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= expire_w & ~restart_w; // see RULE3
    end
  end

  // Node address; a good frame in the expiry cycle cancels the clear, so an address write then still lands
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      node_address_q <= cncd_pkg::DEFAULT_NODE_ADDR; // see RULE9
    end else if (expire_w && !restart_w) begin
      node_address_q <= cncd_pkg::DEFAULT_NODE_ADDR; // see RULE3
    end else if (set_addr_w) begin
      node_address_q <= new_addr_w;
    end
  end

  // Register write port, one-cycle strobe, no response
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_en_q <= 1'b0;
      wr_global_q <= 1'b0;
      wr_addr_q <= 7'h00;
      wr_data_q <= 16'h0000;
    end else begin
      wr_en_q <= do_write_w | do_global_w; // see RULE14
      wr_global_q <= do_global_w;
      if (do_write_w || do_global_w) begin
        wr_addr_q <= rega_w;
        wr_data_q <= data_w;
      end
    end
  end

  // Read sequencer: fetch, then offer, per register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= cncd_pkg::CNCD_IDLE;
      rd_req_q <= 1'b0;
      rd_addr_q <= 7'h00;
      register_transfer_count_q <= 7'h00;
      resp_valid_q <= 1'b0;
      resp_frame_q <= 48'h000000000000;
    end else if (expire_w && !restart_w) begin
      // Abandon any transfer; the node is being reset
      state_q <= cncd_pkg::CNCD_IDLE;
      rd_req_q <= 1'b0;
      resp_valid_q <= 1'b0;
    end else begin
      case (state_q)
        cncd_pkg::CNCD_IDLE: begin
          if (do_read_w) begin
            rd_req_q <= 1'b1;
            rd_addr_q <= rega_w;
            register_transfer_count_q <= xfer_w;
            state_q <= cncd_pkg::CNCD_FETCH;
          end
        end
        cncd_pkg::CNCD_FETCH: begin
          // Read data is sampled at the edge that ends the strobe cycle
          rd_req_q <= 1'b0;
          resp_frame_q <= cncd_build_resp(rd_data_i, rd_addr_q, node_address_q,
                                          response_sequence_count_q);
          resp_valid_q <= 1'b1;
          state_q <= cncd_pkg::CNCD_SEND;
        end
        cncd_pkg::CNCD_SEND: begin
          if (resp_done_w) begin
            resp_valid_q <= 1'b0;
            register_transfer_count_q <= register_transfer_count_q - 7'h01;
            if (last_w) begin
              state_q <= cncd_pkg::CNCD_IDLE;
            end else begin
              // Address wraps from the top back to zero
              rd_addr_q <= (rd_addr_q == cncd_pkg::XFER_MAX) ? 7'h00 : rd_addr_q + 7'h01;
              rd_req_q <= 1'b1;
              state_q <= cncd_pkg::CNCD_FETCH;
            end
          end
        end
        default: begin
          state_q <= cncd_pkg::CNCD_IDLE;
          rd_req_q <= 1'b0;
          resp_valid_q <= 1'b0;
        end
      endcase
    end
  end

  // Response sequence count, counts only responses actually sent
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      response_sequence_count_q <= cncd_pkg::SEQ_RESET;
    end else if (expire_w && !restart_w) begin
      response_sequence_count_q <= cncd_pkg::SEQ_RESET;
    end else if (resp_done_w) begin
      response_sequence_count_q <= response_sequence_count_q + 4'h1; // see RULE13
    end
  end

  // Ready flag, registered so the output comes from a flop
  logic frame_ready_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_ready_q <= 1'b0;
    end else begin
      frame_ready_q <= (state_q == cncd_pkg::CNCD_IDLE) & ~do_read_w;
    end
  end

  // Initialised flag mirrors the address compare
  logic initialized_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      initialized_q <= 1'b0;
    end else begin
      initialized_q <= (node_address_q != cncd_pkg::DEFAULT_NODE_ADDR);
    end
  end

  // Output drive, all straight from flops
  assign frame_ready_o = frame_ready_q;
  assign wr_en_o = wr_en_q;
  assign wr_global_o = wr_global_q;
  assign wr_addr_o = wr_addr_q;
  assign wr_data_o = wr_data_q;
  assign rd_req_o = rd_req_q;
  assign rd_addr_o = rd_addr_q;
  assign resp_valid_o = resp_valid_q;
  assign resp_frame_o = resp_frame_q;
  assign node_address_o = node_address_q;
  assign initialized_o = initialized_q;
  assign soft_reset_o = soft_reset_q;

endmodule : cncd_decoder

`default_nettype wire

// *** cncd_decoder_asserts.sv ***
// Purpose: Port checks for the chain node command decoder
// Assumes: Only the top ports are seen; TIMEOUT_CYCLES is handed on
// Notes: Shadow counters track sequence and quiet time
`default_nettype none
module cncd_chk #(
  parameter int unsigned TIMEOUT_CYCLES = 50
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic frame_valid_i,
  input wire logic [47:0] frame_i,
  input wire logic check_ok_i,
  input wire logic frame_ready_o,
  input wire logic wr_en_o,
  input wire logic wr_global_o,
  input wire logic [6:0] wr_addr_o,
  input wire logic [15:0] wr_data_o,
  input wire logic rd_req_o,
  input wire logic [6:0] rd_addr_o,
  input wire logic [15:0] rd_data_i,
  input wire logic resp_valid_o,
  input wire logic [47:0] resp_frame_o,
  input wire logic resp_ready_i,
  input wire logic [5:0] node_address_o,
  input wire logic initialized_o,
  input wire logic soft_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] seq_q; // Expected sequence of next response
  logic [31:0] idle_q; // Cycles since last good frame
  wire logic good = frame_valid_i && frame_ready_o && check_ok_i && !frame_i[31];
  // Shadow counters; soft reset clears both
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_q <= 4'h0;
      idle_q <= 32'h0;
    end else begin
      seq_q <= soft_reset_o ? 4'h0 : seq_q + 4'(resp_valid_o && resp_ready_i);
      idle_q <= (good || soft_reset_o) ? 32'h0 : idle_q + 32'h1;
    end
  end
  resp_hold_a: assert property (resp_valid_o && !resp_ready_i |=>
    resp_valid_o && $stable(resp_frame_o)) else $error("response not held");
  resp_layout_a: assert property (resp_valid_o |-> resp_frame_o[31:22] ==
    {1'b1, resp_frame_o[30:24], 2'h0} && resp_frame_o[11:8] == 4'h1 &&
    resp_frame_o[21:16] == node_address_o) else $error("response layout wrong");
  seq_count_a: assert property (resp_valid_o |->
    resp_frame_o[15:12] == seq_q) else $error("response sequence wrong");
  read_answer_a: assert property (rd_req_o |-> ##1 resp_valid_o &&
    resp_frame_o[47:32] == $past(rd_data_i) && resp_frame_o[30:24] == $past(rd_addr_o))
    else $error("read answer wrong");
  write_cause_a: assert property (wr_en_o |-> $past(frame_valid_i && check_ok_i) &&
    wr_addr_o == $past(frame_i[30:24]) && wr_data_o == $past(frame_i[47:32]))
    else $error("write without matching frame");
  keepalive_quiet_a: assert property (frame_valid_i && frame_ready_o &&
    frame_i[9:8] == 2'h0 |=> !wr_en_o && !rd_req_o) else $error("keepalive acted");
  refused_frame_a: assert property (frame_valid_i && frame_ready_o &&
    (!check_ok_i || frame_i[31]) |=> !wr_en_o && !rd_req_o) else $error("bad frame acted");
  unassigned_lock_a: assert property (wr_en_o && !initialized_o |->
    wr_addr_o == 7'h01) else $error("write while unassigned");
  timeout_span_a: assert property (soft_reset_o |-> idle_q + 32'h2 >= TIMEOUT_CYCLES &&
    idle_q <= TIMEOUT_CYCLES + 32'h2) else $error("timeout off span");
  timeout_clear_a: assert property (soft_reset_o |=>
    node_address_o == 6'h00) else $error("address kept after timeout");
  cover property (resp_valid_o && resp_ready_i);
  cover property (wr_en_o && wr_global_o);
  cover property (soft_reset_o);
endmodule : cncd_chk
bind cncd_decoder cncd_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .frame_valid_i(frame_valid_i), .frame_i(frame_i),
  .check_ok_i(check_ok_i), .frame_ready_o(frame_ready_o), .wr_en_o(wr_en_o),
  .wr_global_o(wr_global_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
  .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
  .resp_valid_o(resp_valid_o), .resp_frame_o(resp_frame_o), .resp_ready_i(resp_ready_i),
  .node_address_o(node_address_o), .initialized_o(initialized_o),
  .soft_reset_o(soft_reset_o));
`default_nettype wire

// *** cncd_far_model.sv ***
// Purpose: Register store and transmitter beside the decoder
// Assumes: Read data must stand in the cycle of the read strobe
// Notes: Outside that slot the data lines toggle, never hold
`default_nettype none
module cncd_far_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [6:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic rd_req_i,
  input wire logic [6:0] rd_addr_i,
  input wire logic resp_valid_i,
  input wire logic [3:0] stall_i, // Cycles to hold off acceptance
  output logic [15:0] rd_data_o,
  output logic resp_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem_q [128]; // Register contents, preset A5xx
  logic [15:0] junk_q; // Toggling filler outside the read slot
  logic [3:0] wait_q; // Stall count, counts up to stall_i
  initial begin
    for (int i = 0; i < 128; i++) mem_q[i] = 16'hA500 | 16'(i);
    junk_q = 16'h5A5A;
  end
  // Store writes; filler flips every cycle so a late sample shows
  always @(posedge clk_i) begin
    if (wr_en_i) mem_q[wr_addr_i] <= wr_data_i;
    junk_q <= ~junk_q;
  end
  // Read data stands only while the strobe is high
  assign rd_data_o = rd_req_i ? mem_q[rd_addr_i] : junk_q;
  // Transmitter: slow or prompt, holds ready until taken
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 4'h0;
      resp_ready_o <= 1'b0;
    end else if (resp_valid_i && resp_ready_o) begin
      wait_q <= 4'h0;
      resp_ready_o <= 1'b0;
    end else if (resp_valid_i && wait_q >= stall_i) resp_ready_o <= 1'b1;
    else if (resp_valid_i) wait_q <= wait_q + 4'h1;
  end
endmodule : cncd_far_model
`default_nettype wire

// *** tb.sv ***
// Purpose: Self-checking bench for the command decoder
// Assumes: Timeout shortened to 50 cycles
// Notes: Strobes are tallied by a monitor
`default_nettype none
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %s exp=%0h got=%0h", what, exp, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic frame_valid_i = 1'b0;
  logic check_ok_i = 1'b1;
  logic [47:0] frame_i = 48'h0;
  logic [3:0] stall = 4'h0; // Transmitter hold-off
  logic frame_ready_o, wr_en_o, wr_global_o, rd_req_o, resp_valid_o, resp_ready_i;
  logic initialized_o, soft_reset_o;
  logic [6:0] wr_addr_o, rd_addr_o;
  logic [15:0] wr_data_o, rd_data_i;
  logic [47:0] resp_frame_o;
  logic [5:0] node_address_o;
  int miscompares = 0, n_tests = 0, n_wr = 0, n_rd = 0, n_sr = 0, n_gl = 0;
  logic [47:0] resp_q [$]; // Accepted responses
  always #50 clk_i = ~clk_i;
  cncd_decoder #(.TIMEOUT_CYCLES(50)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .frame_valid_i(frame_valid_i), .frame_i(frame_i), .check_ok_i(check_ok_i),
    .frame_ready_o(frame_ready_o), .wr_en_o(wr_en_o), .wr_global_o(wr_global_o),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o),
    .rd_data_i(rd_data_i), .resp_valid_o(resp_valid_o), .resp_frame_o(resp_frame_o),
    .resp_ready_i(resp_ready_i), .node_address_o(node_address_o),
    .initialized_o(initialized_o), .soft_reset_o(soft_reset_o));
  cncd_far_model u_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_o),
    .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o), .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o),
    .resp_valid_i(resp_valid_o), .stall_i(stall), .rd_data_o(rd_data_i),
    .resp_ready_o(resp_ready_i));
  // Tally strobes and keep every accepted response
  always @(posedge clk_i) begin
    n_wr += int'(wr_en_o);
    n_gl += int'(wr_en_o && wr_global_o);
    n_rd += int'(rd_req_o);
    n_sr += int'(soft_reset_o);
    if (resp_valid_o && resp_ready_i) resp_q.push_back(resp_frame_o);
  end
  // Frame with odd don't-care fields, check byte left to the framer
  function automatic logic [47:0] mk(logic [1:0] c, logic [5:0] n, logic [6:0] r,
      logic [15:0] d, logic dir);
    return {d, dir, r, 2'h1, n, 4'hA, 2'h3, c, 8'h00};
  endfunction : mk
  // One-cycle frame strobe, then settle time
  task automatic send(logic [47:0] f, logic ok);
    @(negedge clk_i);
    frame_valid_i = 1'b1;
    frame_i = f;
    check_ok_i = ok;
    @(negedge clk_i);
    frame_valid_i = 1'b0;
    frame_i = ~f;
    repeat (3) @(negedge clk_i);
  endtask : send
  task automatic t_assign();
    int w = n_wr;
    send(mk(cncd_pkg::CMD_WRITE, 6'h00, 7'h03, 16'h1234, 1'b0), 1'b1);
    `CHK("locked write", w, n_wr)
    send(mk(cncd_pkg::CMD_WRITE, 6'h00, 7'h01, 16'h0005, 1'b0), 1'b1);
    `CHK("assign write", w + 1, n_wr)
    `CHK("node address", 6'h05, node_address_o)
    $display("t_assign done");
  endtask : t_assign
  task automatic t_write();
    int w = n_wr;
    send(mk(cncd_pkg::CMD_WRITE, 6'h05, 7'h03, 16'hBEEF, 1'b0), 1'b1);
    `CHK("write data", 16'hBEEF, wr_data_o)
    send(mk(cncd_pkg::CMD_WRITE, 6'h06, 7'h04, 16'h1111, 1'b0), 1'b1);
    send(mk(cncd_pkg::CMD_WRITE, 6'h05, 7'h04, 16'h2222, 1'b1), 1'b1);
    send(mk(cncd_pkg::CMD_WRITE, 6'h05, 7'h04, 16'h3333, 1'b0), 1'b0);
    `CHK("refused frames", w + 1, n_wr)
    send(mk(cncd_pkg::CMD_GLOBAL, 6'h2A, 7'h06, 16'h4444, 1'b0), 1'b1);
    `CHK("global write", w + 2, n_wr)
    `CHK("global addr", 7'h06, wr_addr_o)
    `CHK("global flag", 1, n_gl)
    $display("t_write done");
  endtask : t_write
  task automatic t_read();
    stall = 4'h3;
    send(mk(cncd_pkg::CMD_READ, 6'h05, 7'h7F, 16'h0002, 1'b0), 1'b1);
    `CHK("ready in read", 1'b0, frame_ready_o)
    repeat (60) if (resp_q.size() < 2) @(negedge clk_i);
    send(mk(cncd_pkg::CMD_READ, 6'h05, 7'h03, 16'h0000, 1'b0), 1'b1);
    repeat (60) if (resp_q.size() < 3) @(negedge clk_i);
    `CHK("responses", 3, resp_q.size())
    `CHK("resp 0", {16'hA57F, 1'b1, 7'h7F, 8'h05, 4'h0, 4'h1, 8'h00}, resp_q[0])
    `CHK("resp 1", {16'hA500, 1'b1, 7'h00, 8'h05, 4'h1, 4'h1, 8'h00}, resp_q[1])
    `CHK("resp 2", {16'hBEEF, 1'b1, 7'h03, 8'h05, 4'h2, 4'h1, 8'h00}, resp_q[2])
    $display("t_read done");
  endtask : t_read
  task automatic t_keep();
    int w = n_wr;
    int r = n_rd;
    for (int i = 0; i < 4; i++) begin
      send(mk(cncd_pkg::CMD_KEEPALIVE, 6'h05, 7'h01, 16'h0009, 1'b0), 1'b1);
      repeat (25) @(negedge clk_i);
    end
    `CHK("keepalive resets", 0, n_sr)
    `CHK("keepalive strobes", w + r, n_wr + n_rd)
    `CHK("keepalive address", 6'h05, node_address_o)
    $display("t_keep done");
  endtask : t_keep
  task automatic t_timeout();
    repeat (60) @(negedge clk_i);
    `CHK("timeout pulse", 1, n_sr)
    `CHK("cleared address", 6'h00, node_address_o)
    $display("t_timeout done");
  endtask : t_timeout
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    t_assign();
    t_write();
    t_read();
    t_keep();
    t_timeout();
    close_out();
  end
  // Watchdog: tests need about 250 cycles, allow 2000
  initial begin
    #(100 * 2000);
    miscompares++;
    close_out();
  end
endmodule : tb
`default_nettype wire
